// ### include/acs_regs.svh
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define ACS_IDX_CTRLA 6'h00
`define ACS_IDX_CTRLB 6'h01
`define ACS_IDX_CTRLC 6'h02
`define ACS_IDX_CTRLD 6'h03
`define ACS_IDX_CTRLE 6'h04
`define ACS_IDX_SAMPCTRL 6'h05
`define ACS_IDX_CHANSEL 6'h06
`define ACS_IDX_COMMAND 6'h08
`define ACS_IDX_EVCTRL 6'h09
`define ACS_IDX_INTFLAGS 6'h0B
`define ACS_IDX_RESULT 6'h10
`define ACS_IDX_WIN_LO 6'h12
`define ACS_IDX_WIN_HI 6'h14
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ACS_CTRLA_EN 0
`define ACS_CTRLA_BITW 2
`define ACS_CTRLC_DIV_LSB 0
`define ACS_CTRLC_REF_LSB 4
`define ACS_CMD_START 0
`define ACS_EV_START 0
`define ACS_FLAG_RDY 0
`define ACS_FLAG_WIN 1
// ------------------------------------------------------------
// Reset values, codes and timing counts
// ------------------------------------------------------------
`define ACS_RST_BYTE 8'h00
`define ACS_RST_WORD 16'h0000
`define ACS_CONV_CYCLES 6'h0D
`define ACS_SAMPLE_BASE 6'h02
`define ACS_TEMP_CHAN 5'h1E
`define ACS_MAX_CODE 10'h3FF
`define ACS_MAX_SAMPNUM 3'h6
`endif

// ### include/acs_pkg.sv
package acs_pkg;
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ACS_IDLE = 3'b001,
    ACS_WAIT = 3'b010,
    ACS_CONV = 3'b100
  } acs_state_t;

  // Window comparator modes
  typedef enum logic [2:0] {
    ACS_WIN_OFF = 3'h0,
    ACS_WIN_BELOW = 3'h1,
    ACS_WIN_ABOVE = 3'h2,
    ACS_WIN_INSIDE = 3'h3,
    ACS_WIN_OUTSIDE = 3'h4
  } acs_winmode_t;

  // Control bundle toward the analog converter core
  typedef struct packed {
    logic [4:0] chan;
    logic [1:0] reference_select;
    logic temp_en;
    logic start;
    logic hold;
  } acs_core_ctrl_t;
endpackage : acs_pkg

// ### rtl/acs_prescaler.sv
`timescale 1ns/100ps
`include "acs_regs.svh"
module acs_prescaler #(
  parameter int SEL_W = 3,
  parameter int CNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic run,
  input wire logic [SEL_W-1:0] div_sel,
  output logic tick
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] half;
  logic [CNT_W-1:0] last;

  // Half and full period of the conversion clock
  assign half = {{(CNT_W-1){1'b0}}, 1'b1} << div_sel;
  assign last = CNT_W'((half << 1) - 1'b1);
  // Rising edge of the conversion clock
  assign tick = enable && run && (cnt_q == half);

  // Counter held at zero when off or idle, which fixes start latency
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (!enable || !run)
      cnt_q <= '0;
    else if (cnt_q == last)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  AST_DIV_CLEARED: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> (cnt_q == '0 && !tick))
    else $error("divider not cleared while disabled");
endmodule : acs_prescaler

// ### rtl/acs_sequencer.sv
// Contract
// - Divider counts while enabled outside idle and is cleared to zero while disabled.
// - A start request begins conversion at the next conversion clock edge.
// - Divider held reset when idle; start latency is half factor plus 2.
// - A normal conversion lasts 13 conversion clock cycles.
// - Sample-and-hold occurs 2 conversion cycles after start without delays.
// - On completion the result is stored and the ready flag set.
// - Reading the result or writing one to the flag clears ready.
// - Sampling time is 2 plus sample delay plus sample length cycles.
// - Channel and reference shadows follow into active selection when idle.
// - Selections freeze during conversion and track again in its last cycle.
// - Input above reference yields the maximum code 0x3FF, or 0x0FF in eight-bit mode.
// - Channel code 0x1E routes and enables the temperature sensor.
// - Window flag raised below, above, inside or outside per mode.
// - Comparator uses low/high thresholds and runs only for nonzero mode.
// - With accumulation, compare only after the last sample.
// - An enabled touch controller owns the first instance exclusively.
// - With event start enabled an incoming event starts a conversion.
// - Start bit reads one while converting, cleared at completion.
// - Event input is edge sensitive; each rising edge sets the start bit.
// - Eight-bit mode drops the two low bits before accumulate or store.
`timescale 1ns/100ps
`include "acs_regs.svh"
module acs_sequencer #(
  parameter bit FIRST_INSTANCE = 1'b1,
  parameter int RES_W = 10,
  parameter int ACC_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_in,
  input wire logic touch_active,
  input wire logic touch_start,
  input wire logic [4:0] touch_channel,
  input wire logic [RES_W-1:0] core_result,
  input wire logic core_overrange,
  output acs_pkg::acs_core_ctrl_t core_ctrl
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  acs_pkg::acs_state_t state_q;
  logic en_q, bitw_q, evstart_en_q;
  logic [2:0] sampnum_q, div_sel_q, win_mode_q;
  logic [1:0] ref_shadow_q, ref_act_q;
  logic [4:0] chan_shadow_q, chan_act_q, samp_len_q;
  logic [3:0] samp_delay_q;
  logic [ACC_W-1:0] win_lo_q, win_hi_q, result_q, acc_q, acc_d;
  logic ready_q, win_q, temp_en_q, start_q, hold_q;
  logic ev_s1_q, ev_s2_q, ev_s3_q, ev_edge;
  logic [6:0] samp_cnt_q, samp_total;
  logic [5:0] cyc_q, last_cyc, hold_cyc;
  logic [RES_W-1:0] sample_v;
  logic [31:0] prdata_q, rd_mux;
  logic slverr_q, mapped, apb_wr, result_rd, sw_start, touch_mode;
  logic req, tick, conv_tick, done, last_acc, win_hit, track;
  logic [4:0] chan_src;
  logic [5:0] idx;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign idx = paddr[7:2];
  always_comb
  begin
    mapped = (paddr[1:0] == 2'b00);
    case (idx)
      `ACS_IDX_CTRLA, `ACS_IDX_CTRLB, `ACS_IDX_CTRLC, `ACS_IDX_CTRLD,
      `ACS_IDX_CTRLE, `ACS_IDX_SAMPCTRL, `ACS_IDX_CHANSEL,
      `ACS_IDX_COMMAND, `ACS_IDX_EVCTRL, `ACS_IDX_INTFLAGS,
      `ACS_IDX_RESULT, `ACS_IDX_WIN_LO, `ACS_IDX_WIN_HI: mapped = mapped;
      default: mapped = 1'b0;
    endcase
  end
  assign apb_wr = psel && penable && pwrite && mapped;
  assign result_rd = psel && penable && !pwrite && mapped && (idx == `ACS_IDX_RESULT);
  // Zero wait states; read data and error are prepared in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = slverr_q;

  // Read mux, narrow registers sit in the low bits
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `ACS_IDX_CTRLA: rd_mux[7:0] = {5'h00, bitw_q, 1'b0, en_q};
      `ACS_IDX_CTRLB: rd_mux[2:0] = sampnum_q;
      `ACS_IDX_CTRLC: rd_mux[7:0] = {2'h0, ref_shadow_q, 1'b0, div_sel_q};
      `ACS_IDX_CTRLD: rd_mux[3:0] = samp_delay_q;
      `ACS_IDX_CTRLE: rd_mux[2:0] = win_mode_q;
      `ACS_IDX_SAMPCTRL: rd_mux[4:0] = samp_len_q;
      `ACS_IDX_CHANSEL: rd_mux[4:0] = chan_shadow_q;
      `ACS_IDX_COMMAND: rd_mux[0] = (state_q != acs_pkg::ACS_IDLE);
      `ACS_IDX_EVCTRL: rd_mux[0] = evstart_en_q;
      `ACS_IDX_INTFLAGS: rd_mux[1:0] = {win_q, ready_q};
      `ACS_IDX_RESULT: rd_mux[ACC_W-1:0] = result_q;
      `ACS_IDX_WIN_LO: rd_mux[ACC_W-1:0] = win_lo_q;
      `ACS_IDX_WIN_HI: rd_mux[ACC_W-1:0] = win_hi_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Capture answer in setup; unmapped or misaligned answers with an error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_q <= mapped ? rd_mux : 32'h0000_0000;
      slverr_q <= !mapped;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= 1'b0;
      bitw_q <= 1'b0;
      sampnum_q <= 3'h0;
      div_sel_q <= 3'h0;
      ref_shadow_q <= 2'h0;
      samp_delay_q <= 4'h0;
      win_mode_q <= 3'h0;
      samp_len_q <= 5'h00;
      chan_shadow_q <= 5'h00;
      evstart_en_q <= 1'b0;
      win_lo_q <= `ACS_RST_WORD;
      win_hi_q <= `ACS_RST_WORD;
    end
    else if (apb_wr)
    begin
      case (idx)
        `ACS_IDX_CTRLA:
        begin
          en_q <= pwdata[`ACS_CTRLA_EN];
          bitw_q <= pwdata[`ACS_CTRLA_BITW];
        end
        `ACS_IDX_CTRLB: sampnum_q <= pwdata[2:0];
        `ACS_IDX_CTRLC:
        begin
          div_sel_q <= pwdata[`ACS_CTRLC_DIV_LSB +: 3];
          ref_shadow_q <= pwdata[`ACS_CTRLC_REF_LSB +: 2];
        end
        `ACS_IDX_CTRLD: samp_delay_q <= pwdata[3:0];
        `ACS_IDX_CTRLE: win_mode_q <= pwdata[2:0];
        `ACS_IDX_SAMPCTRL: samp_len_q <= pwdata[4:0];
        `ACS_IDX_CHANSEL: chan_shadow_q <= pwdata[4:0];
        `ACS_IDX_EVCTRL: evstart_en_q <= pwdata[`ACS_EV_START];
        `ACS_IDX_WIN_LO: win_lo_q <= pwdata[ACC_W-1:0];
        `ACS_IDX_WIN_HI: win_hi_q <= pwdata[ACC_W-1:0];
        default: en_q <= en_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Start sources
  // ------------------------------------------------------------
  // Event pin is asynchronous; edge seen only past the second flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_s1_q <= 1'b0;
      ev_s2_q <= 1'b0;
      ev_s3_q <= 1'b0;
    end
    else
    begin
      ev_s1_q <= event_in;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end
  assign ev_edge = ev_s2_q && !ev_s3_q;
  assign touch_mode = FIRST_INSTANCE && touch_active;
  assign sw_start = apb_wr && (idx == `ACS_IDX_COMMAND) && pwdata[`ACS_CMD_START];
  // Touch controller locks out software and event starts while it owns us
  assign req = touch_mode ? touch_start
             : (sw_start || (evstart_en_q && ev_edge));

  // ------------------------------------------------------------
  // Conversion timing
  // ------------------------------------------------------------
  acs_prescaler #(
    .SEL_W(3),
    .CNT_W(8)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .enable(en_q),
    .run(state_q != acs_pkg::ACS_IDLE),
    .div_sel(div_sel_q),
    .tick(tick)
  );

  // Extra sample cycles stretch both the hold point and the end
  // Hold fires at the end of the last sampling cycle, hence the minus one
  assign hold_cyc = `ACS_SAMPLE_BASE - 6'h01 + {2'h0, samp_delay_q}
                  + {1'b0, samp_len_q};
  assign last_cyc = `ACS_CONV_CYCLES + {2'h0, samp_delay_q} + {1'b0, samp_len_q}
                  - 6'h01;
  assign samp_total = 7'((7'h01 << ((sampnum_q > `ACS_MAX_SAMPNUM) ?
                      `ACS_MAX_SAMPNUM : sampnum_q)) - 7'h01);
  assign conv_tick = (state_q == acs_pkg::ACS_CONV) && tick;
  assign done = conv_tick && (cyc_q == last_cyc);
  assign last_acc = done && (samp_cnt_q == samp_total);

  // Sequencer; a request outside idle simply has no transition
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= acs_pkg::ACS_IDLE;
    else if (!en_q)
      state_q <= acs_pkg::ACS_IDLE;
    else
    begin
      case (state_q)
        acs_pkg::ACS_IDLE: if (req) state_q <= acs_pkg::ACS_WAIT;
        acs_pkg::ACS_WAIT: if (tick) state_q <= acs_pkg::ACS_CONV;
        acs_pkg::ACS_CONV: if (last_acc) state_q <= acs_pkg::ACS_IDLE;
        default: state_q <= acs_pkg::ACS_IDLE;
      endcase
    end
  end

  // Conversion cycle and sample counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc_q <= 6'h00;
      samp_cnt_q <= 7'h00;
    end
    else if (state_q == acs_pkg::ACS_WAIT)
    begin
      cyc_q <= 6'h00;
      samp_cnt_q <= 7'h00;
    end
    else if (conv_tick)
    begin
      cyc_q <= done ? 6'h00 : cyc_q + 6'h01;
      if (done)
        samp_cnt_q <= samp_cnt_q + 7'h01;
    end
  end

  // ------------------------------------------------------------
  // Result path
  // ------------------------------------------------------------
  // Over-range saturates; eight-bit mode discards two low bits
  assign sample_v = bitw_q
                  ? ((core_overrange ? `ACS_MAX_CODE : core_result) >> 2)
                  : (core_overrange ? `ACS_MAX_CODE : core_result);
  assign acc_d = acc_q + {{(ACC_W-RES_W){1'b0}}, sample_v};

  // Window test on the finished accumulation only
  always_comb
  begin
    case (acs_pkg::acs_winmode_t'(win_mode_q))
      acs_pkg::ACS_WIN_BELOW: win_hit = acc_d < win_lo_q;
      acs_pkg::ACS_WIN_ABOVE: win_hit = acc_d > win_hi_q;
      acs_pkg::ACS_WIN_INSIDE: win_hit = (acc_d > win_lo_q) && (acc_d < win_hi_q);
      acs_pkg::ACS_WIN_OUTSIDE: win_hit = (acc_d < win_lo_q) || (acc_d > win_hi_q);
      default: win_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q <= `ACS_RST_WORD;
      result_q <= `ACS_RST_WORD;
    end
    else if (state_q == acs_pkg::ACS_WAIT)
      acc_q <= `ACS_RST_WORD;
    else if (done)
    begin
      acc_q <= acc_d;
      if (last_acc)
        result_q <= acc_d;
    end
  end

  // Flags: a completion in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ready_q <= 1'b0;
      win_q <= 1'b0;
    end
    else
    begin
      if (last_acc)
        ready_q <= 1'b1;
      else if (result_rd || (apb_wr && idx == `ACS_IDX_INTFLAGS && pwdata[`ACS_FLAG_RDY]))
        ready_q <= 1'b0;
      if (last_acc && win_hit)
        win_q <= 1'b1;
      else if (apb_wr && idx == `ACS_IDX_INTFLAGS && pwdata[`ACS_FLAG_WIN])
        win_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Active selections and core control
  // ------------------------------------------------------------
  assign chan_src = touch_mode ? touch_channel : chan_shadow_q;
  assign track = (state_q != acs_pkg::ACS_CONV) || (cyc_q == last_cyc);

  // Frozen while converting so sampling sees a stable input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_act_q <= 5'h00;
      ref_act_q <= 2'h0;
      temp_en_q <= 1'b0;
    end
    else if (track)
    begin
      chan_act_q <= chan_src;
      ref_act_q <= ref_shadow_q;
      temp_en_q <= (chan_src == `ACS_TEMP_CHAN);
    end
  end

  // Start pulse per sample, hold pulse at end of sampling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q <= 1'b0;
      hold_q <= 1'b0;
    end
    else
    begin
      start_q <= ((state_q == acs_pkg::ACS_WAIT) && tick) || (done && !last_acc);
      hold_q <= conv_tick && (cyc_q == hold_cyc);
    end
  end

  assign core_ctrl = '{chan: chan_act_q, reference_select: ref_act_q, temp_en: temp_en_q,
                       start: start_q, hold: hold_q};

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_launch;
    (state_q == acs_pkg::ACS_WAIT) && tick;
  endsequence
  sequence s_started;
    (state_q == acs_pkg::ACS_CONV) && (cyc_q == 6'h00) && start_q;
  endsequence

  AST_START_EDGE: assert property (s_launch |=> s_started)
    else $error("conversion did not begin on conversion clock edge");
  AST_IDLE_NO_TICK: assert property ((state_q == acs_pkg::ACS_IDLE) |-> !tick)
    else $error("divider ran while idle");
  // Plain timing at divide by four: thirteen cycles of four clocks each
  AST_LENGTH: assert property (start_q && en_q && div_sel_q == 3'h1
    && samp_delay_q == 4'h0 && samp_len_q == 5'h00 |-> ##51 done)
    else $error("conversion length wrong");
  AST_HOLD_POINT: assert property (hold_q |-> $past(cyc_q) + 6'h01 == `ACS_SAMPLE_BASE
    + {2'h0, samp_delay_q} + {1'b0, samp_len_q})
    else $error("sample-and-hold at wrong cycle");
  AST_READY_SET: assert property (last_acc |=> ready_q && result_q == $past(acc_d))
    else $error("result or ready flag missing after completion");
  AST_READY_CLR: assert property (result_rd && !last_acc |=> !ready_q)
    else $error("ready flag survived result read");
  AST_LOCKED: assert property ((state_q == acs_pkg::ACS_CONV) && !track
    |=> $stable(chan_act_q) && $stable(ref_act_q))
    else $error("selection changed during conversion");
  AST_FOLLOW: assert property ((state_q == acs_pkg::ACS_IDLE) && !touch_mode
    |=> chan_act_q == $past(chan_shadow_q))
    else $error("active channel not following shadow");
  AST_SATURATE: assert property (done && core_overrange && !bitw_q
    |-> sample_v == `ACS_MAX_CODE)
    else $error("over-range did not give maximum code");
  AST_TEMP: assert property (temp_en_q == (chan_act_q == `ACS_TEMP_CHAN))
    else $error("temperature sensor enable mismatch");
  AST_NO_RESTART: assert property ((state_q == acs_pkg::ACS_CONV) && req && !last_acc
    |=> state_q == acs_pkg::ACS_CONV)
    else $error("request disturbed running conversion");
  AST_WIN_ONCE: assert property (win_q && !$past(win_q) |-> $past(last_acc))
    else $error("window flag raised outside last sample");
endmodule : acs_sequencer

// ### test/acs_core_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Analog core stand-in
// ----------------------------------------
module acs_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire acs_pkg::acs_core_ctrl_t core_ctrl,
  input wire logic over_req,
  output logic [9:0] core_result,
  output logic core_overrange
);
  // Sample taken on hold; per-channel code keeps channels apart
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_result <= 10'h000;
      core_overrange <= 1'b0;
    end
    else if (core_ctrl.hold)
    begin
      core_result <= {1'b0, core_ctrl.chan, 4'h5};
      core_overrange <= over_req;
    end
  end
endmodule : acs_core_model

// ### test/adc_conversion_sequencer_tb.sv
`timescale 1ns/100ps
`include "acs_regs.svh"
module adc_conversion_sequencer_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic event_in = 1'b0;
  logic touch_active = 1'b0;
  logic touch_start = 1'b0;
  logic [9:0] core_result;
  logic core_overrange;
  logic over_req = 1'b0;
  acs_pkg::acs_core_ctrl_t core_ctrl;
  logic [4:0] chs [3] = '{5'h01, 5'h03, 5'h1E};
  logic [31:0] q;
  logic err;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int n_start = 0;
  int t_start = 0;
  int t_hold = 0;
  int t_acc = 0;
  int s;

  // Clock flips every half period
  always #5 pclk = ~pclk;

  acs_sequencer acs_sequencer_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_in(event_in), .touch_active(touch_active),
    .touch_start(touch_start), .touch_channel(5'h07), .core_result(core_result),
    .core_overrange(core_overrange), .core_ctrl(core_ctrl));

  acs_core_model acs_core_model_inst (.pclk(pclk), .presetn(presetn), .core_ctrl(core_ctrl),
    .over_req(over_req), .core_result(core_result), .core_overrange(core_overrange));

  // Edge stamps of start and hold; hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (core_ctrl.start === 1'b1)
    begin
      n_start <= n_start + 1;
      t_start <= cyc;
    end
    if (core_ctrl.hold === 1'b1)
      t_hold <= cyc;
    if (cyc == 20000)
    begin
      fails++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // One APB transfer; idle edge after so strobes never toggle twice at once
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    t_acc = cyc;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rdc(input string nm, input logic [5:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    chk(nm, e, q);
  endtask : rdc

  task automatic wait_to(input int c);
    while (cyc < c)
      @(posedge pclk);
  endtask : wait_to

  // Polls the ready flag; reading flags never clears them
  task automatic wait_rdy();
    q = 32'h0;
    while (q[0] !== 1'b1)
      apb(1'b0, `ACS_IDX_INTFLAGS, 32'h0);
  endtask : wait_rdy

  task automatic conv(input logic [4:0] ch, input logic [31:0] e);
    apb(1'b1, `ACS_IDX_CHANSEL, {27'h0, ch});
    apb(1'b1, `ACS_IDX_COMMAND, 32'h1);
    wait_rdy();
    rdc("result", `ACS_IDX_RESULT, e);
  endtask : conv

  function automatic logic [31:0] val(input logic [4:0] ch);
    return {23'h0, ch, 4'h5};
  endfunction : val

  // Expected window flag for thresholds 0x020 and 0x100
  function automatic logic win_exp(input int m, input logic [31:0] r);
    case (m)
      1: return r < 32'h20;
      2: return r > 32'h100;
      3: return r > 32'h20 && r < 32'h100;
      4: return r < 32'h20 || r > 32'h100;
      default: return 1'b0;
    endcase
  endfunction : win_exp

  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("ctrla", `ACS_IDX_CTRLA, 32'h0);
    rdc("flags", `ACS_IDX_INTFLAGS, 32'h0);
    apb(1'b0, 6'h07, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test reset done");
    // Divide by 4, internal reference; latency 4, conversion 52 edges
    apb(1'b1, `ACS_IDX_CTRLC, 32'h1);
    apb(1'b1, `ACS_IDX_CTRLA, 32'h1);
    apb(1'b1, `ACS_IDX_CHANSEL, 32'h3);
    apb(1'b1, `ACS_IDX_COMMAND, 32'h1);
    s = t_acc;
    rdc("busy", `ACS_IDX_COMMAND, 32'h1);
    apb(1'b1, `ACS_IDX_COMMAND, 32'h1);
    apb(1'b1, `ACS_IDX_CHANSEL, 32'h9);
    chk("latency", 32'h4, 32'(t_start - s));
    wait_to(t_start + 44);
    chk("frozen", 32'h3, {27'h0, core_ctrl.chan});
    chk("hold", 32'h8, 32'(t_hold - t_start));
    rdc("still busy", `ACS_IDX_COMMAND, 32'h1);
    wait_to(t_start + 53);
    rdc("done", `ACS_IDX_COMMAND, 32'h0);
    rdc("ready", `ACS_IDX_INTFLAGS, 32'h1);
    chk("tracking", 32'h9, {27'h0, core_ctrl.chan});
    rdc("result", `ACS_IDX_RESULT, val(5'h03));
    rdc("cleared", `ACS_IDX_INTFLAGS, 32'h0);
    chk("one start", 32'h1, 32'(n_start));
    $display("test timing done");
    apb(1'b1, `ACS_IDX_CTRLD, 32'h1);
    apb(1'b1, `ACS_IDX_SAMPCTRL, 32'h2);
    apb(1'b1, `ACS_IDX_COMMAND, 32'h1);
    wait_rdy();
    chk("hold delayed", 32'h14, 32'(t_hold - t_start));
    apb(1'b1, `ACS_IDX_INTFLAGS, 32'h1);
    rdc("w1c", `ACS_IDX_INTFLAGS, 32'h0);
    apb(1'b1, `ACS_IDX_CTRLD, 32'h0);
    apb(1'b1, `ACS_IDX_SAMPCTRL, 32'h0);
    over_req <= 1'b1;
    conv(5'h03, 32'h3FF);
    over_req <= 1'b0;
    apb(1'b1, `ACS_IDX_CTRLA, 32'h5);
    conv(5'h03, val(5'h03) >> 2);
    apb(1'b1, `ACS_IDX_CTRLA, 32'h1);
    apb(1'b1, `ACS_IDX_CHANSEL, 32'h1E);
    @(posedge pclk);
    chk("temp", 32'h78, {25'h0, core_ctrl.chan, core_ctrl.reference_select});
    chk("temp en", 32'h1, {31'h0, core_ctrl.temp_en});
    $display("test result done");
    apb(1'b1, `ACS_IDX_WIN_LO, 32'h20);
    apb(1'b1, `ACS_IDX_WIN_HI, 32'h100);
    foreach (chs[i])
    begin
      for (int m = 0; m <= 4; m++)
      begin
        apb(1'b1, `ACS_IDX_CTRLE, 32'(m));
        conv(chs[i], val(chs[i]));
        apb(1'b0, `ACS_IDX_INTFLAGS, 32'h0);
        chk("window", {31'h0, win_exp(m, val(chs[i]))}, {31'h0, q[1]});
        apb(1'b1, `ACS_IDX_INTFLAGS, 32'h3);
      end
    end
    apb(1'b1, `ACS_IDX_CTRLB, 32'h1);
    apb(1'b1, `ACS_IDX_CTRLE, 32'h3);
    s = n_start;
    conv(5'h03, 32'h6A);
    chk("samples", 32'h2, 32'(n_start - s));
    apb(1'b0, `ACS_IDX_INTFLAGS, 32'h0);
    chk("acc window", 32'h2, q);
    apb(1'b1, `ACS_IDX_CTRLB, 32'h0);
    $display("test window done");
    s = n_start;
    event_in <= 1'b1;
    repeat (40) @(posedge pclk);
    event_in <= 1'b0;
    chk("event off", 32'(s), 32'(n_start));
    apb(1'b1, `ACS_IDX_EVCTRL, 32'h1);
    event_in <= 1'b1;
    wait_rdy();
    repeat (100) @(posedge pclk);
    event_in <= 1'b0;
    chk("event edge", 32'(s + 1), 32'(n_start));
    apb(1'b1, `ACS_IDX_INTFLAGS, 32'h3);
    touch_active <= 1'b1;
    apb(1'b1, `ACS_IDX_COMMAND, 32'h1);
    repeat (8) @(posedge pclk);
    chk("touch lock", 32'(s + 1), 32'(n_start));
    chk("touch chan", 32'h7, {27'h0, core_ctrl.chan});
    touch_start <= 1'b1;
    @(posedge pclk);
    touch_start <= 1'b0;
    wait_rdy();
    chk("touch start", 32'(s + 2), 32'(n_start));
    touch_active <= 1'b0;
    $display("test event done");
    finish_test();
  end
endmodule : adc_conversion_sequencer_tb
